/* File: hdl/cmom_pkg.sv */
// cmom_pkg: constants, opcodes and register map for the move/or/multiply
// slice; assumes a single pclk domain and an APB register front end.
`default_nettype none
package cmom_pkg;
   // register byte offsets
   localparam logic [7:0] CMOM_OFS_INSTR = 8'h00;
   localparam logic [7:0] CMOM_OFS_INSTR2 = 8'h04;
   localparam logic [7:0] CMOM_OFS_CTRL = 8'h08;
   localparam logic [7:0] CMOM_OFS_STATUS = 8'h0C;
   localparam logic [7:0] CMOM_OFS_WREG = 8'h10;
   localparam logic [7:0] CMOM_OFS_BANKSEL = 8'h14;
   localparam logic [7:0] CMOM_OFS_PROD = 8'h18;
   localparam logic [7:0] CMOM_OFS_PTR01 = 8'h1C;
   localparam logic [7:0] CMOM_OFS_PTR2 = 8'h20;
   localparam logic [7:0] CMOM_OFS_MEMADDR = 8'h24;
   localparam logic [7:0] CMOM_OFS_MEMDATA = 8'h28;
   // control / status bit positions
   localparam int CMOM_CTRL_EXT_BIT = 0;
   localparam int CMOM_ST_Z_BIT = 0;
   localparam int CMOM_ST_N_BIT = 1;
   localparam int CMOM_ST_BUSY_BIT = 2;
   localparam int CMOM_ST_BAD_BIT = 3;
   // opcode prefixes
   localparam logic [7:0] CMOM_OP_ORI = 8'h09;
   localparam logic [7:0] CMOM_OP_BANK_SELECT_LOAD_OP = 8'h01;
   localparam logic [7:0] CMOM_OP_LDI = 8'h0E;
   localparam logic [7:0] CMOM_OP_MULI = 8'h0D;
   localparam logic [6:0] CMOM_OP_MULR = 7'h01;
   localparam logic [5:0] CMOM_OP_ORR = 6'h04;
   localparam logic [5:0] CMOM_OP_MOVR = 6'h14;
   localparam logic [6:0] CMOM_OP_STW = 7'h37;
   localparam logic [9:0] CMOM_OP_PTRL = 10'h3B8;
   localparam logic [3:0] CMOM_OP_FFM1 = 4'hC;
   localparam logic [3:0] CMOM_OP_FFM2 = 4'hF;
   localparam logic [7:0] CMOM_IDX_LIMIT = 8'h5F;
   localparam logic [7:0] CMOM_ACC_SPLIT = 8'h60;
   localparam logic [3:0] CMOM_ACC_SFR_BANK = 4'hF;
   // working register alias in the data space
   localparam logic [11:0] CMOM_WREG_ADDR = 12'hFE8;
   localparam logic [7:0] CMOM_RST_BYTE = 8'h00;
   localparam int CMOM_MEM_DEPTH = 4096;
   typedef enum logic [1:0] {CMOM_Q1, CMOM_Q2, CMOM_Q3, CMOM_Q4} cmom_phase_t;
endpackage : cmom_pkg
`default_nettype wire

/* File: hdl/cmom_mem_if.sv */
// cmom_mem_if: data memory port bundle between core and memory
// assumes single pclk domain
`default_nettype none
interface cmom_mem_if;
   logic [11:0] raddr;
   logic [7:0] rdata;
   logic we;
   logic [11:0] waddr;
   logic [7:0] wdata;
   modport core (output raddr, output we, output waddr, output wdata,
      input rdata);
   modport mem (input raddr, input we, input waddr, input wdata,
      output rdata);
endinterface : cmom_mem_if
`default_nettype wire

/* File: hdl/cmom_data_mem.sv */
// cmom_data_mem: 4096-byte data space with registered read data
// assumes single pclk domain; contents unspecified after reset
`default_nettype none
module cmom_data_mem
   import cmom_pkg::*;
(
   input wire logic pclk,
   cmom_mem_if.mem port
);
   logic [7:0] mem_r [CMOM_MEM_DEPTH];
   logic [7:0] rdata_r;
   always_ff @(posedge pclk) begin
      if (port.we) begin
         mem_r[port.waddr] <= port.wdata;
      end
      rdata_r <= mem_r[port.raddr];
   end
   assign port.rdata = rdata_r;
endmodule : cmom_data_mem
`default_nettype wire

/* File: hdl/cmom_core.sv */
// cmom_core: move/or/multiply instruction slice with APB register access
// assumes APB master on pclk; instructions issued through INSTR register
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`default_nettype none
// Overview of operation
// RL1: or immediate ors W with literal, writes W, sets N and Z
// RL2: destination bit 0 writes W, 1 writes register back
// RL3: access bit 0 uses access bank, 1 uses bank select register
// RL4: access bit 0 with extended set and address <= 5Fh is indexed
// RL5: register move copies bank location to destination, updates N and Z
// RL6: or register ors W with register to destination, N and Z only
// RL7: pointer load writes 12-bit literal, upper first, lower second cycle
// RL8: full range move uses two words with 12-bit addresses, no flags
// RL9: full range move may use W as source or destination
// RL10: software must not target counter low or stack top bytes
// RL11: full range move reads source first, writes destination last phase
// RL12: bank select load keeps upper four bits zero
// RL13: immediate load puts literal in W, no flags changed
// RL14: store working copies W into addressed register, no flags
// RL15: multiply immediate puts W times literal in product pair
// RL16: multiply register puts W times register in product pair
// RL17: single-word ops decode, read, process, write over four phases
module cmom_core
   import cmom_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   cmom_mem_if mif ();
   cmom_data_mem u_mem (
      .pclk(pclk),
      .port(mif.mem)
   );

   cmom_phase_t phase_r;
   logic busy_r, second_r, ext_r, bad_r, flag_n_r, flag_z_r;
   logic [15:0] ir_r, ir2_r;
   logic [7:0] wreg_r, banksel_r, prod_h_r, prod_l_r, opnd_r, res_r;
   logic [11:0] ptr_r [3];
   logic [11:0] dbg_addr_r;
   logic [7:0] dbg_data_r;

   // bus decode
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_instr = (paddr == CMOM_OFS_INSTR);
   wire hit_instr2 = (paddr == CMOM_OFS_INSTR2);
   wire hit_ctrl = (paddr == CMOM_OFS_CTRL);
   wire hit_status = (paddr == CMOM_OFS_STATUS);
   wire hit_wreg = (paddr == CMOM_OFS_WREG);
   wire hit_bank = (paddr == CMOM_OFS_BANKSEL);
   wire hit_prod = (paddr == CMOM_OFS_PROD);
   wire hit_p01 = (paddr == CMOM_OFS_PTR01);
   wire hit_p2 = (paddr == CMOM_OFS_PTR2);
   wire hit_maddr = (paddr == CMOM_OFS_MEMADDR);
   wire hit_mdata = (paddr == CMOM_OFS_MEMDATA);
   wire mapped = hit_instr | hit_instr2 | hit_ctrl | hit_status | hit_wreg
      | hit_bank | hit_prod | hit_p01 | hit_p2 | hit_maddr | hit_mdata;
   wire issue = wr & hit_instr & ~busy_r;
   // memory port is borrowed for debug access only while idle
   wire mdata_wr = wr & hit_mdata & ~busy_r;

   // instruction field decode
   wire [7:0] hi = ir_r[15:8];
   wire [7:0] lit = ir_r[7:0];
   wire dbit = ir_r[9];
   wire abit = ir_r[8];
   wire is_ori = (hi == CMOM_OP_ORI);
   wire is_bank_select_load_op = (hi == CMOM_OP_BANK_SELECT_LOAD_OP);
   wire is_ldi = (hi == CMOM_OP_LDI);
   wire is_muli = (hi == CMOM_OP_MULI);
   wire is_mulr = (ir_r[15:9] == CMOM_OP_MULR);
   wire is_orr = (ir_r[15:10] == CMOM_OP_ORR);
   wire is_movr = (ir_r[15:10] == CMOM_OP_MOVR);
   wire is_stw = (ir_r[15:9] == CMOM_OP_STW);
   wire is_ptrl = (ir_r[15:6] == CMOM_OP_PTRL) && (ir_r[5:4] != 2'b11);
   wire is_ffm = (ir_r[15:12] == CMOM_OP_FFM1);
   wire two_word = is_ptrl | is_ffm;
   wire known = is_ori | is_bank_select_load_op | is_ldi | is_muli | is_mulr | is_orr
      | is_movr | is_stw | is_ptrl | is_ffm;
   wire second_ok = is_ptrl ? (ir2_r[15:8] == {CMOM_OP_FFM2, 4'h0})
      : (ir2_r[15:12] == CMOM_OP_FFM2);
   wire [1:0] ptr_sel = ir_r[5:4];

   // RL3 bank selection
   wire [11:0] bank_addr = {banksel_r[3:0], lit};
   wire [11:0] acc_addr = (lit < CMOM_ACC_SPLIT) ? {4'h0, lit}
      : {CMOM_ACC_SFR_BANK, lit};
   // RL4 indexed literal offset
   wire [11:0] idx_addr = ptr_r[2] + {4'h0, lit};
   wire use_idx = ~abit & ext_r & (lit <= CMOM_IDX_LIMIT);
   wire [11:0] f_addr = abit ? bank_addr : (use_idx ? idx_addr : acc_addr);
   // RL8 full range addresses
   wire [11:0] src_addr = ir_r[11:0];
   wire [11:0] dst_addr = ir2_r[11:0];
   // RL9 W as source
   wire src_is_w = is_ffm & (src_addr == CMOM_WREG_ADDR);
   wire [7:0] rd_val = src_is_w ? wreg_r : mif.rdata;
   wire [15:0] product = {8'h00, wreg_r} * {8'h00, opnd_r};

   // operand and result, process phase
   logic [7:0] res_nxt;
   always_comb begin
      res_nxt = opnd_r;
      if (is_ori | is_orr) begin
         // RL1 RL6 or with W
         res_nxt = wreg_r | opnd_r;
      end else if (is_stw) begin
         // RL14 store W into register
         res_nxt = wreg_r;
      end
   end

   wire wr_w_dest = (is_orr | is_movr) & ~dbit;
   wire wr_f_dest = ((is_orr | is_movr) & dbit) | is_stw;
   wire q4 = busy_r & (phase_r == CMOM_Q4);
   wire ffm_wr = is_ffm & second_r & q4;

   assign mif.raddr = busy_r ? (is_ffm ? src_addr : f_addr) : dbg_addr_r;
   // RL11 destination written in last phase
   assign mif.we = (q4 & ~second_r & wr_f_dest)
      | (ffm_wr & (dst_addr != CMOM_WREG_ADDR)) | mdata_wr;
   assign mif.waddr = busy_r ? (is_ffm ? dst_addr : f_addr) : dbg_addr_r;
   assign mif.wdata = busy_r ? res_r : pwdata[7:0];

   // sequencer: phases advance every clock while busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= CMOM_Q1;
         busy_r <= 1'b0;
         second_r <= 1'b0;
      end else if (!busy_r) begin
         phase_r <= CMOM_Q1;
         busy_r <= issue;
         second_r <= 1'b0;
      end else begin
         // RL17 four phases per cycle
         case (phase_r)
            CMOM_Q1: phase_r <= CMOM_Q2;
            CMOM_Q2: phase_r <= CMOM_Q3;
            CMOM_Q3: phase_r <= CMOM_Q4;
            default: begin
               phase_r <= CMOM_Q1;
               // RL7 RL8 second cycle for two-word ops
               if (two_word & ~second_r & second_ok) begin
                  second_r <= 1'b1;
               end else begin
                  busy_r <= 1'b0;
                  second_r <= 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_r <= 16'h0000;
         ir2_r <= 16'h0000;
      end else begin
         if (issue) begin
            ir_r <= pwdata[15:0];
         end
         if (wr & hit_instr2 & ~busy_r) begin
            ir2_r <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_r <= 1'b0;
      end else if (wr & hit_ctrl) begin
         ext_r <= pwdata[CMOM_CTRL_EXT_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_addr_r <= 12'h000;
      end else if (wr & hit_maddr) begin
         dbg_addr_r <= pwdata[11:0];
      end
   end

   // RL17 operand read in Q2, result formed in Q3, written in Q4
   wire opnd_cap = busy_r & ~second_r & (phase_r == CMOM_Q2);
   wire res_cap = busy_r & (phase_r == CMOM_Q3);
   wire use_mem = is_ffm | is_orr | is_movr | is_mulr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opnd_r <= CMOM_RST_BYTE;
      end else if (opnd_cap) begin
         opnd_r <= use_mem ? rd_val : lit;
      end
   end

   // second cycle of a full range move only passes the operand on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_r <= CMOM_RST_BYTE;
      end else if (res_cap) begin
         res_r <= second_r ? opnd_r : res_nxt;
      end
   end

   // bad opcode flag: sticky until software clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_r <= 1'b0;
      end else if (busy_r & (phase_r == CMOM_Q1) & ~second_r
                   & (~known | (two_word & ~second_ok))) begin
         bad_r <= 1'b1;
      end else if (wr & hit_status & pwdata[CMOM_ST_BAD_BIT]) begin
         bad_r <= 1'b0;
      end
   end

   // architectural register writes in last phase
   wire q4a = q4 & ~second_r;
   // RL1 RL2 RL13 working register result
   wire w_from_op = q4a & (is_ori | is_ldi | wr_w_dest);
   // RL9 W as destination
   wire w_from_ffm = ffm_wr & (dst_addr == CMOM_WREG_ADDR);
   wire w_from_bus = ~busy_r & wr & hit_wreg;
   wire [7:0] w_op_val = is_ldi ? lit : res_r;
   wire [7:0] wreg_nxt = w_from_op ? w_op_val
      : (w_from_ffm ? res_r : pwdata[7:0]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wreg_r <= CMOM_RST_BYTE;
      end else if (w_from_op | w_from_ffm | w_from_bus) begin
         wreg_r <= wreg_nxt;
      end
   end

   // RL5 RL6 N and Z only
   wire flag_upd = q4a & (is_ori | is_orr | is_movr);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_n_r <= 1'b0;
         flag_z_r <= 1'b0;
      end else if (flag_upd) begin
         flag_n_r <= res_r[7];
         flag_z_r <= (res_r == 8'h00);
      end
   end

   // RL12 upper nibble zero
   wire bank_upd = (q4a & is_bank_select_load_op) | (~busy_r & wr & hit_bank);
   wire [3:0] bank_low = busy_r ? lit[3:0] : pwdata[3:0];
   wire [7:0] banksel_nxt = {4'h0, bank_low};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         banksel_r <= CMOM_RST_BYTE;
      end else if (bank_upd) begin
         banksel_r <= banksel_nxt;
      end
   end

   // RL15 RL16 product pair
   wire prod_upd = q4a & (is_muli | is_mulr);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prod_h_r <= CMOM_RST_BYTE;
         prod_l_r <= CMOM_RST_BYTE;
      end else if (prod_upd) begin
         prod_h_r <= product[15:8];
         prod_l_r <= product[7:0];
      end
   end

   // RL7 pointer load, upper then lower
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ptr
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ptr_r[g] <= 12'h000;
            end else if (is_ptrl & q4 & (ptr_sel == 2'(g))) begin
               if (!second_r) begin
                  ptr_r[g][11:8] <= ir_r[3:0];
               end else begin
                  ptr_r[g][7:0] <= ir2_r[7:0];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_data_r <= CMOM_RST_BYTE;
      end else begin
         dbg_data_r <= mif.rdata;
      end
   end

   // read mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_instr) begin
         rd_mux = {16'h0000, ir_r};
      end else if (hit_instr2) begin
         rd_mux = {16'h0000, ir2_r};
      end else if (hit_ctrl) begin
         rd_mux = {31'h0000_0000, ext_r};
      end else if (hit_status) begin
         rd_mux = {28'h000_0000, bad_r, busy_r, flag_n_r, flag_z_r};
      end else if (hit_wreg) begin
         rd_mux = {24'h00_0000, wreg_r};
      end else if (hit_bank) begin
         rd_mux = {24'h00_0000, banksel_r};
      end else if (hit_prod) begin
         rd_mux = {16'h0000, prod_h_r, prod_l_r};
      end else if (hit_p01) begin
         rd_mux = {4'h0, ptr_r[1], 4'h0, ptr_r[0]};
      end else if (hit_p2) begin
         rd_mux = {20'h0_0000, ptr_r[2]};
      end else if (hit_maddr) begin
         rd_mux = {20'h0_0000, dbg_addr_r};
      end else if (hit_mdata) begin
         rd_mux = {24'h00_0000, dbg_data_r};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable) begin
         prdata <= rd_mux;
      end
   end

   assign pready = acc;
   assign pslverr = acc & ~mapped;
endmodule : cmom_core
`default_nettype wire

/* File: sim/cmom_core_props.sv */
// cmom_core_props: protocol and field checks on the core's register port
// assumes one pclk domain; attached to cmom_core by the bind below
`default_nettype none
module cmom_core_props
   import cmom_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   wire logic rd_acc = acc && !pwrite;
   wire logic bad = paddr > CMOM_OFS_MEMDATA || paddr[1:0] != 2'h0;
   zero_wait_a: assert property (acc |-> pready)
      else $error("access phase without ready");
   idle_ready_a: assert property (!psel |-> !pready)
      else $error("ready while not selected");
   err_qual_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_err_a: assert property (acc && bad |-> pslverr)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc && !bad |-> !pslverr)
      else $error("mapped access refused");
   unmapped_zero_a: assert property (rd_acc && bad |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (acc ##1 !psel |-> $stable(prdata))
      else $error("read data moved after access");
   bank_upper_a: assert property (
      rd_acc && paddr == CMOM_OFS_BANKSEL |-> prdata[31:4] == 28'h0)
      else $error("bank select upper bits set");
   ptr_width_a: assert property (
      rd_acc && paddr == CMOM_OFS_PTR2 |-> prdata[31:12] == 20'h0)
      else $error("pointer wider than 12 bits");
   ptr_pair_a: assert property (
      rd_acc && paddr == CMOM_OFS_PTR01 |->
      prdata[31:28] == 4'h0 && prdata[15:12] == 4'h0)
      else $error("pointer pair wider than 12 bits");
   status_bits_a: assert property (
      rd_acc && paddr == CMOM_OFS_STATUS |-> prdata[31:4] == 28'h0)
      else $error("status spare bits set");
   cover property (acc && pwrite && paddr == CMOM_OFS_INSTR);
   cover property (acc && bad);
   cover property (rd_acc && paddr == CMOM_OFS_STATUS &&
      prdata[CMOM_ST_BUSY_BIT]);
endmodule : cmom_core_props
bind cmom_core cmom_core_props u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: sim/cmom_apb_master.sv */
// cmom_apb_master: APB master model standing in for software
// assumes one pclk domain; the bench calls xfer for each transfer
`default_nettype none
module cmom_apb_master
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data no longer shows the last value
      pwdata <= ~d;
   endtask : xfer
endmodule : cmom_apb_master
`default_nettype wire

/* File: sim/tb_top.sv */
// tb_top: self-checking bench for the move/or/multiply slice
// assumes cmom_core with its data memory, reached through APB only
`default_nettype none
module tb_top
   import cmom_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] w;
      logic [15:0] i1;
      logic [15:0] i2;
      logic [7:0] ew;
      logic [1:0] st;
      logic [11:0] ck;
      logic [31:0] ev;
   } cmom_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   // ck: 0 none, below 100h a register offset, else a data address
   // no move targets the counter low or stack top bytes
   cmom_row_t rows [18] = '{
      '{8'h9A, 16'h0935, 16'h0, 8'hBF, 2'h2, 12'h0, 32'h0},
      '{8'h00, 16'h0E5A, 16'h0, 8'h5A, 2'h2, 12'h0, 32'h0},
      '{8'h00, 16'h0900, 16'h0, 8'h00, 2'h1, 12'h0, 32'h0},
      '{8'h4F, 16'h6F20, 16'h0, 8'h4F, 2'h1, 12'h220, 32'h4F},
      '{8'h91, 16'h1105, 16'h0, 8'h93, 2'h2, 12'h0, 32'h0},
      '{8'hFF, 16'h5105, 16'h0, 8'h13, 2'h0, 12'h0, 32'h0},
      '{8'hFF, 16'h5033, 16'h0, 8'h44, 2'h0, 12'h0, 32'h0},
      '{8'h20, 16'h1305, 16'h0, 8'h20, 2'h0, 12'h205, 32'h33},
      '{8'h00, 16'h5320, 16'h0, 8'h00, 2'h0, 12'h220, 32'h4F},
      '{8'hE2, 16'h0DC4, 16'h0, 8'hE2, 2'h0, 12'h18, 32'hAD08},
      '{8'hC4, 16'h0310, 16'h0, 8'hC4, 2'h0, 12'h18, 32'h8A94},
      '{8'h00, 16'hEE23, 16'hF0AB, 8'h00, 2'h0, 12'h20, 32'h3AB},
      '{8'h00, 16'hEE01, 16'hF023, 8'h00, 2'h0, 12'h1C, 32'h123},
      '{8'h00, 16'hEE1F, 16'hF0FF, 8'h00, 2'h0, 12'h1C, 32'h0FFF0123},
      '{8'h00, 16'hC205, 16'hF230, 8'h00, 2'h0, 12'h230, 32'h33},
      '{8'h00, 16'hC205, 16'hFFE8, 8'h33, 2'h0, 12'h0, 32'h0},
      '{8'h77, 16'hCFE8, 16'hF231, 8'h77, 2'h0, 12'h231, 32'h77},
      '{8'h00, 16'h01F5, 16'h0, 8'h00, 2'h0, 12'h14, 32'h5}
   };
   cmom_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   cmom_apb_master u_mst (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic report_and_stop;
      if (mismatches == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         report_and_stop;
      end
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_mst.xfer(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      u_mst.xfer(1'b0, a, 32'h0, r, e);
   endtask : rd
   task automatic poke(input logic [11:0] a, input logic [7:0] d);
      wr(CMOM_OFS_MEMADDR, {20'h0, a});
      wr(CMOM_OFS_MEMDATA, {24'h0, d});
   endtask : poke
   task automatic idle;
      do begin
         rd(CMOM_OFS_STATUS);
      end while (r[CMOM_ST_BUSY_BIT] !== 1'b0);
   endtask : idle
   task automatic op(input logic [15:0] i1, input logic [15:0] i2);
      if (i2 != 16'h0)
         wr(CMOM_OFS_INSTR2, {16'h0, i2});
      wr(CMOM_OFS_INSTR, {16'h0, i1});
      idle;
   endtask : op
   task automatic chkw(input logic [7:0] w, input logic [1:0] st);
      rd(CMOM_OFS_WREG);
      cmp(r, {24'h0, w});
      rd(CMOM_OFS_STATUS);
      cmp(r, {30'h0, st});
   endtask : chkw
   initial begin
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 2; k < 9; k++) begin
         rd(8'(k * 4));
         cmp(r, 32'h0);
      end
      wr(CMOM_OFS_BANKSEL, 32'hF2);
      rd(CMOM_OFS_BANKSEL);
      cmp(r, 32'h2);
      poke(12'h205, 8'h13);
      poke(12'h033, 8'h44);
      poke(12'h210, 8'hB5);
      poke(12'h3B0, 8'h81);
      poke(12'h40A, 8'h00);
      foreach (rows[k]) begin
         wr(CMOM_OFS_WREG, {24'h0, rows[k].w});
         op(rows[k].i1, rows[k].i2);
         chkw(rows[k].ew, rows[k].st);
         if (rows[k].ck >= 12'h100) begin
            wr(CMOM_OFS_MEMADDR, {20'h0, rows[k].ck});
            @(posedge pclk);
            rd(CMOM_OFS_MEMDATA);
         end else if (rows[k].ck != 12'h0)
            rd(rows[k].ck[7:0]);
         if (rows[k].ck != 12'h0)
            cmp(r, rows[k].ev);
      end
      wr(CMOM_OFS_CTRL, 32'h1);
      op(16'h5005, 16'h0);
      chkw(8'h81, 2'h2);
      op(16'h505F, 16'h0);
      chkw(8'h00, 2'h1);
      wr(CMOM_OFS_INSTR, 32'h0E11);
      wr(CMOM_OFS_WREG, 32'h99);
      idle;
      chkw(8'h11, 2'h1);
      wr(CMOM_OFS_INSTR, 32'h0E22);
      rd(CMOM_OFS_STATUS);
      cmp(r & 32'h4, 32'h4);
      idle;
      op(16'hEE30, 16'hF000);
      cmp(r & 32'h8, 32'h8);
      wr(CMOM_OFS_STATUS, 32'h8);
      rd(CMOM_OFS_STATUS);
      cmp(r & 32'h8, 32'h0);
      rd(8'h30);
      cmp({31'h0, e}, 32'h1);
      cmp(r, 32'h0);
      report_and_stop;
   end
endmodule : tb_top
`default_nettype wire
